// ===== verilog/tls_consts.vh
/*
 * Constants of the polled terminal line sharer: register offsets, control
 * field positions, reset values and scan-state codes.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef TLS_CONSTS_VH
`define TLS_CONSTS_VH

// Register byte offsets on the APB bus.
`define TLS_OFF_CTRL    8'h00
`define TLS_OFF_POLL    8'h04
`define TLS_OFF_STATUS  8'h08
`define TLS_OFF_ASYNC   8'h0c

// Control register fields.
`define TLS_CTRL_GRP_LO   0
`define TLS_CTRL_GRP_HI   1
`define TLS_CTRL_PRIO     2
`define TLS_CTRL_MULTI    3
`define TLS_CTRL_FULLDPX  4
`define TLS_CTRL_SYNC     5
`define TLS_CTRL_LEN_LO   6
`define TLS_CTRL_LEN_HI   7
`define TLS_CTRL_CASCADE  8
`define TLS_CTRL_SEQCLR   9
`define TLS_CTRL_W        10
`define TLS_CTRL_RST      10'h0e3

// Poll register command bit and status bit that clears on write of one.
`define TLS_POLL_BIT      0
`define TLS_STAT_NODATA   0

// Character length codes and figures in bits.
`define TLS_LEN_6         2'h0
`define TLS_LEN_7         2'h1
`define TLS_BITS_6        4'h6
`define TLS_BITS_7        4'h7
`define TLS_BITS_8        4'h8
`define TLS_ASYNC_FRAME   4'h2

// Channel groups of four and group thresholds.
`define TLS_GRP_2         2'h1
`define TLS_GRP_3         2'h2
`define TLS_GRP_4         2'h3
`define TLS_GROUP_LOW     4'hf

// Scan states, one-hot.
`define TLS_ST_IDLE       5'h01
`define TLS_ST_WAIT       5'h02
`define TLS_ST_SCAN       5'h04
`define TLS_ST_GRANT      5'h08
`define TLS_ST_DONE       5'h10

// Synchroniser width and positions of the link signals inside it.
`define TLS_SYNC_W        36
`define TLS_SY_RXD        32
`define TLS_SY_CD         33
`define TLS_SY_RXCLK      34
`define TLS_SY_TXCLK      35

`endif

// ===== verilog/tls_sum8.v
/*
 * One summation group of eight terminal channels: the wired-or of requests,
 * the selected channel's request and the selected channel's transmit data.
 * Assumes synchronised inputs and a one-hot or zero select vector.
 */
`timescale 1ns/100ps
`default_nettype none

module tls_sum8 (
    input  wire [7:0] rts,      // Requests of the eight channels.
    input  wire [7:0] txd,      // Transmit data of the eight channels.
    input  wire [7:0] sel,      // One-hot channel select.
    input  wire       grp_en,   // Group fitted.
    output wire       any_rts,  // Some channel of the group requests.
    output wire       sel_rts,  // The selected channel requests.
    output wire       sel_txd   // Data of the selected channel.
);

    // Summation of the group, gated by whether the group is fitted.
    assign any_rts = grp_en & (|rts);
    assign sel_rts = grp_en & (|(rts & sel));
    assign sel_txd = grp_en & (|(txd & sel));

endmodule

`default_nettype wire

// ===== verilog/tls_sharer.v
/*
 * Polled terminal line sharer: shares one modem line among 4 to 16 terminals,
 * broadcasting the received side and granting clear to send to one terminal
 * at a time, with an APB register file for options and status.
 * Assumes pins and modem clocks are asynchronous to pclk and an APB master.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tls_consts.vh"

module tls_sharer (
    input  wire        pclk,          // System clock.
    input  wire        presetn,       // Asynchronous reset, active low.
    input  wire        psel,          // APB select.
    input  wire        penable,       // APB enable.
    input  wire        pwrite,        // APB write.
    input  wire [7:0]  paddr,         // APB byte address.
    input  wire [31:0] pwdata,        // APB write data.
    output reg  [31:0] prdata,        // APB read data.
    output wire        pready,        // APB ready.
    output wire        pslverr,       // APB error for unmapped address.
    input  wire        modem_rxd,     // Received data from modem.
    input  wire        modem_cd,      // Received line signal detector.
    input  wire        modem_rxclk,   // Receiver timing element.
    input  wire        modem_txclk,   // Transmitter timing element.
    output reg         modem_rts,     // Request to send toward modem.
    output reg         modem_txd,     // Transmit data toward modem.
    input  wire [15:0] term_rts,      // Terminal requests to send.
    input  wire [15:0] term_txd,      // Terminal transmit data.
    output reg  [15:0] term_cts,      // Clear to send per terminal.
    output reg  [15:0] term_rxd,      // Broadcast received data.
    output reg  [15:0] term_cd,       // Broadcast carrier detect.
    output reg  [15:0] term_rxclk,    // Broadcast receive clock.
    output reg  [15:0] term_txclk,    // Broadcast transmit clock.
    output reg  [15:0] term_async_en, // Terminals allowed to send async.
    output reg         casc_txclk,    // Serial clock toward a cascade head.
    output reg         casc_rts,      // Summed request toward a cascade head.
    output reg         no_data        // One-cycle no-data pulse toward the site.
);

    reg  [`TLS_SYNC_W-1:0] s1_reg;
    reg  [`TLS_SYNC_W-1:0] s2_reg;
    reg                    txclk_prev_reg;
    reg  [`TLS_CTRL_W-1:0] ctrl_reg;
    reg  [15:0]            async_reg;
    reg                    poll_pend_reg;
    reg                    nodata_sticky_reg;
    reg  [4:0]             state_reg;
    reg  [4:0]             state_next;
    reg  [3:0]             cnt_reg;
    reg  [3:0]             cnt_next;
    reg  [3:0]             chr_reg;
    reg  [3:0]             chr_next;
    reg                    poll_take;
    reg                    nodata_evt;
    reg  [3:0]             char_bits;
    wire [15:0]            rts_s;
    wire [15:0]            txd_s;
    wire [1:0]             grp;
    wire [15:0]            ch_en;
    wire [15:0]            rts_v;
    wire [15:0]            sel;
    wire                   any_lo;
    wire                   any_hi;
    wire                   selr_lo;
    wire                   selr_hi;
    wire                   seld_lo;
    wire                   seld_hi;
    wire                   any_rts;
    wire                   sel_rts;
    wire                   sel_txd;
    wire                   txclk_edge;
    wire                   granting;
    wire                   seq_clr;
    wire                   wr_acc;
    wire                   rd_setup;
    wire                   mapped;
    wire                   poll_wr;
    wire                   nodata_clr;
    wire                   half_block;

    // Two-stage synchroniser for every pin arriving from outside pclk.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= {`TLS_SYNC_W{1'b0}};
            s2_reg <= {`TLS_SYNC_W{1'b0}};
        end else begin
            s1_reg <= {modem_txclk, modem_rxclk, modem_cd, modem_rxd, term_txd, term_rts};
            s2_reg <= s1_reg;
        end
    end

    assign rts_s = s2_reg[15:0];
    assign txd_s = s2_reg[31:16];

    // Edge finder on the synchronised transmitter timing element.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txclk_prev_reg <= 1'b0;
        end else begin
            txclk_prev_reg <= s2_reg[`TLS_SY_TXCLK];
        end
    end

    assign txclk_edge = s2_reg[`TLS_SY_TXCLK] & ~txclk_prev_reg;

    // Channel groups of four enable the fitted channels.
    assign grp   = ctrl_reg[`TLS_CTRL_GRP_HI:`TLS_CTRL_GRP_LO];
    assign ch_en = {{4{grp == `TLS_GRP_4}}, {4{grp >= `TLS_GRP_3}},
                    {4{grp >= `TLS_GRP_2}}, `TLS_GROUP_LOW};
    assign rts_v = rts_s & ch_en;

    // Decode of the scan counter into sixteen exclusive selects.
    assign granting = (state_reg == `TLS_ST_SCAN) | (state_reg == `TLS_ST_GRANT);
    assign sel      = granting ? (16'h0001 << cnt_reg) : 16'h0000;

    // Summation in groups of eight; the upper group is fitted above eight.
    tls_sum8 u_sum_lo (
        .rts     (rts_v[7:0]),
        .txd     (txd_s[7:0]),
        .sel     (sel[7:0]),
        .grp_en  (1'b1),
        .any_rts (any_lo),
        .sel_rts (selr_lo),
        .sel_txd (seld_lo)
    );

    tls_sum8 u_sum_hi (
        .rts     (rts_v[15:8]),
        .txd     (txd_s[15:8]),
        .sel     (sel[15:8]),
        .grp_en  (grp >= `TLS_GRP_3),
        .any_rts (any_hi),
        .sel_rts (selr_hi),
        .sel_txd (seld_hi)
    );

    assign any_rts = any_lo | any_hi;
    assign sel_rts = selr_lo | selr_hi;
    assign sel_txd = seld_lo | seld_hi;

    // Character time in bits of the link, framing added in an async system.
    always @* begin
        case (ctrl_reg[`TLS_CTRL_LEN_HI:`TLS_CTRL_LEN_LO])
            `TLS_LEN_6: char_bits = `TLS_BITS_6;
            `TLS_LEN_7: char_bits = `TLS_BITS_7;
            default:    char_bits = `TLS_BITS_8;
        endcase
        if (!ctrl_reg[`TLS_CTRL_SYNC]) begin
            char_bits = char_bits + `TLS_ASYNC_FRAME;
        end
    end

    assign seq_clr = ctrl_reg[`TLS_CTRL_SEQCLR];

    // Scan sequencer: delay, scan, grant and wait for a further poll.
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        chr_next   = chr_reg;
        poll_take  = 1'b0;
        nodata_evt = 1'b0;
        case (state_reg)
            `TLS_ST_IDLE: begin
                chr_next = 4'h0;
                if (any_rts | poll_pend_reg) begin
                    state_next = `TLS_ST_WAIT;
                end
            end
            `TLS_ST_WAIT: begin
                if (chr_reg >= char_bits) begin
                    poll_take = poll_pend_reg;
                    if (any_rts) begin
                        state_next = `TLS_ST_SCAN;
                    end else begin
                        nodata_evt = poll_pend_reg;
                        state_next = `TLS_ST_IDLE;
                    end
                end else if (txclk_edge) begin
                    chr_next = chr_reg + 4'h1;
                end
            end
            `TLS_ST_SCAN: begin
                if (!any_rts) begin
                    state_next = `TLS_ST_IDLE;
                end else if (sel_rts) begin
                    state_next = `TLS_ST_GRANT;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            `TLS_ST_GRANT: begin
                if (!sel_rts) begin
                    if (ctrl_reg[`TLS_CTRL_MULTI]) begin
                        state_next = `TLS_ST_SCAN;
                    end else begin
                        state_next = `TLS_ST_DONE;
                    end
                    if (ctrl_reg[`TLS_CTRL_PRIO]) begin
                        cnt_next = 4'h0;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            `TLS_ST_DONE: begin
                if (poll_pend_reg) begin
                    poll_take  = 1'b1;
                    state_next = `TLS_ST_SCAN;
                end else if (!any_rts) begin
                    state_next = `TLS_ST_IDLE;
                end
            end
            default: begin
                state_next = `TLS_ST_IDLE;
            end
        endcase
        if (!any_rts) begin
            cnt_next = 4'h0;
        end
    end

    // Sequencer registers, also cleared on command from software.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= `TLS_ST_IDLE;
            cnt_reg   <= 4'h0;
            chr_reg   <= 4'h0;
        end else if (seq_clr) begin
            state_reg <= `TLS_ST_IDLE;
            cnt_reg   <= 4'h0;
            chr_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            chr_reg   <= chr_next;
        end
    end

    // APB decode; registers answer with no wait states.
    assign pready     = 1'b1;
    assign mapped     = (paddr == `TLS_OFF_CTRL) | (paddr == `TLS_OFF_POLL) |
                        (paddr == `TLS_OFF_STATUS) | (paddr == `TLS_OFF_ASYNC);
    assign pslverr    = psel & penable & ~mapped;
    assign wr_acc     = psel & penable & pwrite & mapped;
    assign rd_setup   = psel & ~penable & ~pwrite;
    assign poll_wr    = wr_acc & (paddr == `TLS_OFF_POLL) & pwdata[`TLS_POLL_BIT];
    assign nodata_clr = wr_acc & (paddr == `TLS_OFF_STATUS) & pwdata[`TLS_STAT_NODATA];

    // Writable option registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= `TLS_CTRL_RST;
            async_reg <= 16'h0000;
        end else begin
            if (wr_acc & (paddr == `TLS_OFF_CTRL)) begin
                ctrl_reg <= pwdata[`TLS_CTRL_W-1:0];
            end
            if (wr_acc & (paddr == `TLS_OFF_ASYNC)) begin
                async_reg <= pwdata[15:0];
            end
        end
    end

    // Poll pending and no-data flags; a set beats a clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_pend_reg     <= 1'b0;
            nodata_sticky_reg <= 1'b0;
        end else begin
            if (poll_wr) begin
                poll_pend_reg <= 1'b1;
            end else if (poll_take | seq_clr) begin
                poll_pend_reg <= 1'b0;
            end
            if (nodata_evt & ~seq_clr) begin
                nodata_sticky_reg <= 1'b1;
            end else if (nodata_clr) begin
                nodata_sticky_reg <= 1'b0;
            end
        end
    end

    // Read data is captured in the setup cycle and stands in the access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `TLS_OFF_CTRL:   prdata <= {22'h000000, ctrl_reg};
                `TLS_OFF_STATUS: prdata <= {rts_v, 3'h0, state_reg, cnt_reg,
                                            any_rts, 1'b0, poll_pend_reg, nodata_sticky_reg};
                `TLS_OFF_ASYNC:  prdata <= {16'h0000, async_reg};
                default:         prdata <= 32'h00000000;
            endcase
        end
    end

    assign half_block = ~ctrl_reg[`TLS_CTRL_FULLDPX] & (state_reg == `TLS_ST_GRANT);

    // Modem and terminal outputs, all from flip-flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_rts     <= 1'b0;
            modem_txd     <= 1'b1;
            term_cts      <= 16'h0000;
            term_rxd      <= 16'hffff;
            term_cd       <= 16'h0000;
            term_rxclk    <= 16'h0000;
            term_txclk    <= 16'h0000;
            term_async_en <= 16'h0000;
            casc_txclk    <= 1'b0;
            casc_rts      <= 1'b0;
            no_data       <= 1'b0;
        end else begin
            modem_rts  <= any_rts;
            modem_txd  <= (state_reg == `TLS_ST_GRANT) ? sel_txd : 1'b1;
            term_cts   <= ((state_reg == `TLS_ST_GRANT) & sel_rts & ~seq_clr) ?
                          sel : 16'h0000;
            term_rxd   <= {16{s2_reg[`TLS_SY_RXD] | half_block}};
            term_cd    <= {16{s2_reg[`TLS_SY_CD]}};
            term_rxclk <= {16{s2_reg[`TLS_SY_RXCLK]}};
            term_txclk <= {16{s2_reg[`TLS_SY_TXCLK]}};
            term_async_en <= ctrl_reg[`TLS_CTRL_SYNC] ? (async_reg & ch_en) : 16'h0000;
            casc_txclk <= ctrl_reg[`TLS_CTRL_CASCADE] & s2_reg[`TLS_SY_TXCLK];
            casc_rts   <= ctrl_reg[`TLS_CTRL_CASCADE] & any_rts;
            no_data    <= nodata_evt & ~seq_clr;
        end
    end

endmodule

`default_nettype wire

// ===== testbench/tls_sharer_sva.sv
/*
 * Port checker of the terminal line sharer.
 * Assumes it is bound to tls_sharer and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module tls_sharer_sva (
    input wire logic        pclk,      // Clock.
    input wire logic        presetn,   // Reset, active low.
    input wire logic        psel,      // APB select.
    input wire logic        penable,   // APB enable.
    input wire logic [7:0]  paddr,     // APB address.
    input wire logic        pslverr,   // APB error.
    input wire logic        modem_cd,  // Carrier in.
    input wire logic        modem_rts, // Request out.
    input wire logic        modem_txd, // Data out.
    input wire logic [15:0] term_rts,  // Requests.
    input wire logic [15:0] term_txd,  // Terminal data.
    input wire logic [15:0] term_cts,  // Grants.
    input wire logic [15:0] term_cd,   // Carrier copies.
    input wire logic        no_data    // No-data pulse.
);
    // Every check runs on the system clock and rests during reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_cts_onehot: assert property ($onehot0(term_cts))
        else $error("more than one grant");
    a_cts_hold: assert property (term_cts != 16'h0 && $past(term_cts) != 16'h0 |-> term_cts == $past(term_cts))
        else $error("grant moved without release");
    a_cts_cause: assert property ((term_cts & ~$past(term_rts, 3)) == 16'h0)
        else $error("grant to a silent terminal");
    a_txd_path: assert property (term_cts != 16'h0 && $past(term_cts, 4) == term_cts
        && (term_cts & term_rts & $past(term_rts, 3)) == term_cts
        |-> modem_txd == |(term_cts & $past(term_txd, 3)))
        else $error("line data not from granted terminal");
    a_rts_cause: assert property (modem_rts |-> $past(term_rts, 3) != 16'h0)
        else $error("line request without terminal request");
    a_rts_off: assert property ((term_rts == 16'h0) [*4] |-> !modem_rts)
        else $error("line request stuck");
    a_cd_bcast: assert property (term_cd == {16{$past(modem_cd, 3)}})
        else $error("carrier not broadcast");
    a_scan_delay: assert property ($rose(modem_rts) |-> (term_cts == 16'h0) [*8])
        else $error("grant without scan delay");
    a_nodata_pulse: assert property (no_data |=> !no_data ##1 !no_data)
        else $error("no-data longer than one cycle");
    a_nodata_quiet: assert property (no_data |-> !modem_rts)
        else $error("no-data while requests pending");
    a_bus_error: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h0c))
        else $error("bus error flag wrong");
endmodule
bind tls_sharer tls_sharer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .modem_cd(modem_cd), .modem_rts(modem_rts), .modem_txd(modem_txd),
    .term_rts(term_rts), .term_txd(term_txd), .term_cts(term_cts), .term_cd(term_cd), .no_data(no_data));
`default_nettype wire

// ===== testbench/tls_modem_model.sv
/*
 * Modem at the line side of the terminal line sharer.
 * Assumes free-running timing elements, as a synchronous modem supplies.
 */
`timescale 1ns/100ps
`default_nettype none
module tls_modem_model (
    input wire logic  frame_on,    // Carrier present.
    input wire logic  modem_rts,   // Request from block.
    input wire logic  modem_txd,   // Data from block.
    output logic       modem_rxd,   // Received data.
    output logic       modem_cd,    // Carrier detect.
    output logic       modem_rxclk, // Receive timing.
    output logic       modem_txclk, // Transmit timing.
    output logic [7:0] rx_shift     // Last bits sent by block.
);
    // Timing runs at 125 ns, receive timing offset in phase.
    initial begin
        modem_txclk = 1'b0;
        modem_rxclk = 1'b0;
        modem_rxd = 1'b1;
        rx_shift = 8'hff;
        #20;
        forever #62.5 modem_rxclk = ~modem_rxclk;
    end
    always #62.5 modem_txclk = ~modem_txclk;
    assign modem_cd = frame_on;
    // Data flips every bit so a stale value never looks valid.
    always @(negedge modem_rxclk) modem_rxd <= ~modem_rxd;
    // Capture what the block sends while it asks for the line.
    always @(posedge modem_txclk) if (modem_rts) rx_shift <= {rx_shift[6:0], modem_txd};
endmodule
`default_nettype wire

// ===== testbench/tls_sharer_tb.sv
/*
 * Self-checking bench of the terminal line sharer.
 * Assumes tls_sharer, its checker and the modem model.
 */
`timescale 1ns/100ps
`default_nettype none
module tls_sharer_tb;
    logic        pclk = 1'b0, presetn, psel, penable, pwrite, frame_on;
    logic [7:0]  paddr, rx_shift;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, e, modem_rxd, modem_cd, modem_rxclk, modem_txclk;
    logic        modem_rts, modem_txd, casc_txclk, casc_rts, no_data;
    logic [15:0] term_rts, term_txd, term_cts, term_rxd, term_cd, term_rxclk, term_txclk, term_async_en;
    int          error_cnt = 0, comparisons = 0;
    always #5 pclk = ~pclk;
    tls_sharer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modem_rxd(modem_rxd), .modem_cd(modem_cd), .modem_rxclk(modem_rxclk), .modem_txclk(modem_txclk),
        .modem_rts(modem_rts), .modem_txd(modem_txd), .term_rts(term_rts), .term_txd(term_txd),
        .term_cts(term_cts), .term_rxd(term_rxd), .term_cd(term_cd), .term_rxclk(term_rxclk),
        .term_txclk(term_txclk), .term_async_en(term_async_en), .casc_txclk(casc_txclk),
        .casc_rts(casc_rts), .no_data(no_data));
    tls_modem_model modem (.frame_on(frame_on), .modem_rts(modem_rts), .modem_txd(modem_txd),
        .modem_rxd(modem_rxd), .modem_cd(modem_cd), .modem_rxclk(modem_rxclk),
        .modem_txclk(modem_txclk), .rx_shift(rx_shift));
    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is seen.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rts(input logic [15:0] v);
        @(posedge pclk);
        term_rts <= v;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task automatic wait_cts(input logic [15:0] exp, input string what);
        repeat (600) begin
            @(negedge pclk);
            if (term_cts === exp) break;
        end
        check(term_cts, exp, what);
    endtask
    // Reset values, unmapped access and the write-only poll register.
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        check(q, 32'h0e3, "control reset");
        apb(1'b0, 8'h10, 32'h0);
        check(q, 32'h0, "unmapped read data");
        check(e, 1'b1, "unmapped read error");
        apb(1'b0, 8'h04, 32'h0);
        check(q, 32'h0, "poll reads zero");
    endtask
    // One terminal gets the line, its data reaches the modem.
    task automatic t_grant();
        apb(1'b1, 8'h00, 32'h0eb);
        term_txd <= 16'hfffb;
        rts(16'h0004);
        wait_cts(16'h0004, "grant channel 2");
        check(modem_rts, 1'b1, "line request");
        check(term_rxd, 16'hffff, "half duplex blank");
        check({casc_rts, casc_txclk}, 2'h0, "cascade idle");
        idle(150);
        check(rx_shift, 8'h00, "line data");
        rts(16'h0);
        wait_cts(16'h0, "release");
        idle(10);
        apb(1'b0, 8'h08, 32'h0);
        check(q[12:4], 9'h010, "idle and counter clear");
        term_txd <= 16'hffff;
    endtask
    // A newcomer below the granted channel is served next only with priority.
    task automatic t_order(input logic [31:0] ctrl, input logic [15:0] second);
        apb(1'b1, 8'h00, ctrl);
        rts(16'h0044);
        wait_cts(16'h0004, "first found");
        rts(16'h0046);
        idle(20);
        rts(16'h0042);
        wait_cts(second, "next in order");
        rts(16'h0);
        wait_cts(16'h0, "all released");
    endtask
    // Single mode waits for a poll before the second terminal.
    task automatic t_single();
        apb(1'b1, 8'h00, 32'h0e3);
        rts(16'h0011);
        wait_cts(16'h0001, "single first");
        rts(16'h0010);
        idle(300);
        check(term_cts, 16'h0, "held until poll");
        apb(1'b1, 8'h04, 32'h1);
        wait_cts(16'h0010, "after poll");
        rts(16'h0);
        wait_cts(16'h0, "single released");
    endtask
    // A poll with nobody requesting gives one no-data event.
    task automatic t_nodata();
        logic seen;
        seen = 1'b0;
        apb(1'b1, 8'h04, 32'h1);
        repeat (600) begin
            @(negedge pclk);
            if (no_data === 1'b1) seen = 1'b1;
        end
        check(seen, 1'b1, "no-data pulse");
        apb(1'b0, 8'h08, 32'h0);
        check(q[0], 1'b1, "no-data sticky");
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        check(q[0], 1'b0, "no-data cleared");
    endtask
    // Channel count, async allowance, cascade outputs and sequencer clear.
    task automatic t_config();
        apb(1'b1, 8'h00, 32'h0e9);
        rts(16'h1000);
        idle(300);
        check({modem_rts, term_cts}, 17'h0, "unfitted channel ignored");
        rts(16'h0080);
        wait_cts(16'h0080, "last fitted channel");
        rts(16'h0);
        wait_cts(16'h0, "fitted released");
        apb(1'b1, 8'h0c, 32'h0000ffff);
        idle(4);
        check(term_async_en, 16'h00ff, "async allowance");
        apb(1'b1, 8'h00, 32'h0c9);
        idle(4);
        check(term_async_en, 16'h0, "async needs sync system");
        apb(1'b1, 8'h00, 32'h1eb);
        rts(16'h0008);
        idle(10);
        check(casc_rts, 1'b1, "cascade request");
        wait_cts(16'h0008, "cascade grant");
        @(posedge modem_txclk);
        idle(6);
        check({term_txclk, term_rxclk}, 32'hffffffff, "timing broadcast");
        check(casc_txclk, 1'b1, "cascade clock");
        apb(1'b1, 8'h00, 32'h2eb);
        idle(3);
        check(term_cts, 16'h0, "sequencer clear");
        rts(16'h0);
        apb(1'b1, 8'h00, 32'h0eb);
        frame_on <= 1'b1;
        idle(40);
        check(term_cd, 16'hffff, "carrier broadcast");
        @(posedge pclk);
        frame_on <= 1'b0;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Main sequence after 12 cycles of reset.
    initial begin
        {presetn, psel, penable, pwrite, frame_on} = 5'h0;
        {paddr, pwdata, term_rts} = 56'h0;
        term_txd = 16'hffff;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_grant();
        t_order(32'h0eb, 16'h0040);
        t_order(32'h0ef, 16'h0002);
        t_single();
        t_nodata();
        t_config();
        wrap_up();
    end
    // Cuts a hang short.
    initial begin
        #500000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
